// File: core/sgc_consts.svh
// Register offsets, field positions and reset values of the global control bank
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH

// Byte addresses; multi-byte registers are big-endian, MSB at the base address
`define SGC_ADDR_PWR_CTL 16'h0006
`define SGC_ADDR_VARIANT 16'h000F
`define SGC_ADDR_GSTAT 16'h0010
`define SGC_ADDR_GMASK 16'h0014
`define SGC_ADDR_PSTAT 16'h0018
`define SGC_ADDR_PMASK 16'h001C
`define SGC_ADDR_SIO_CTL 16'h0100

// Field positions
`define SGC_PWR_EN_BIT 1
`define SGC_PWR_POL_BIT 0
`define SGC_GLB_LOOKUP_BIT 31
`define SGC_GLB_GPIO_BIT 30
`define SGC_SIO_PRE_BIT 2
`define SGC_SIO_AUTO_BIT 1
`define SGC_SIO_EDGE_BIT 0

// Reset values
`define SGC_PWR_CTL_RST 8'h00
`define SGC_SIO_CTL_RST 8'h42
`define SGC_GMASK_RST 2'h0
`define SGC_PMASK_RST 3'h0
`define SGC_RDATA_RST 8'h00

// Number of switch ports summarised
`define SGC_NUM_PORTS 3

`endif

// File: core/sgc_pkg.sv
// State types of the global control and interrupt register bank
package sgc_pkg;

	// Register-bank state of the top module
	typedef struct packed {
		logic [7:0] pwr_ctl;
		logic [7:0] sio_ctl;
		logic [1:0] gmask;
		logic [2:0] pmask;
		logic [7:0] rdata;
		logic rvalid;
		logic pwr_pin_o;
		logic pwr_pin_oe;
	} sgc_top_state_t;

	// Interrupt aggregation state
	typedef struct packed {
		logic [1:0] gstat;
		logic [2:0] pstat;
		logic irq_b;
	} sgc_irq_state_t;

	// Serial I/O option state
	typedef struct packed {
		logic preamble_opt;
		logic sdo_rising;
	} sgc_sio_state_t;

endpackage

// File: core/sgc_irq_if.sv
// Masks, summary status and interrupt line between register bank and aggregator
`timescale 1ns/1ns
interface sgc_irq_if;
	logic [1:0] gmask;
	logic [2:0] pmask;
	logic [1:0] gstat;
	logic [2:0] pstat;
	logic irq_b;

	modport regs (output gmask, output pmask, input gstat, input pstat, input irq_b);
	modport agg (input gmask, input pmask, output gstat, output pstat, output irq_b);
endinterface

// File: core/sgc_irq_agg.sv
// Two-level interrupt aggregation: global and port summary status behind masks
`timescale 1ns/1ns
module sgc_irq_agg
	import sgc_pkg::*;
#(
	parameter int NUM_PORTS = 3
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_lookup_irq,
	input wire logic i_gpio_irq,
	input wire logic [2:0] i_port_irq,
	sgc_irq_if.agg irq
);
`include "sgc_consts.svh"

	// The register holds a fixed three-bit port field
	generate
		if (NUM_PORTS != `SGC_NUM_PORTS) begin : g_bad_ports
			$error("sgc_irq_agg: NUM_PORTS must match the port summary field");
		end
	endgenerate

	sgc_irq_state_t st_ff;
	sgc_irq_state_t nxt_st;

	// Status tracks the source levels; no latching, the sources hold the cause
	always_comb begin
		nxt_st = st_ff;
		nxt_st.gstat = {i_lookup_irq, i_gpio_irq};
		nxt_st.pstat = i_port_irq;
		// Mask bit set suppresses; either level can raise the line
		nxt_st.irq_b = ~(|(st_ff.gstat & ~irq.gmask) | |(st_ff.pstat & ~irq.pmask));
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= '{gstat: 2'h0, pstat: 3'h0, irq_b: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign irq.gstat = st_ff.gstat;
	assign irq.pstat = st_ff.pstat;
	assign irq.irq_b = st_ff.irq_b;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// Status is still reset at the release edge, so those edges start no check
	chk_glb_status_follow: assert property (
		i_rst_b |=> irq.gstat == $past({i_lookup_irq, i_gpio_irq}))
		else $error("global status does not follow its sources");
	chk_gpio_status_bit: assert property (
		(i_rst_b && i_gpio_irq) |=> irq.gstat[0])
		else $error("gpio status bit not set");
	chk_port_status_follow: assert property (
		(i_rst_b && $rose(i_port_irq[2])) |=> irq.pstat[2])
		else $error("port 3 summary status not set");
	chk_glb_mask_gate: assert property (
		(irq.gmask == 2'h3 && irq.pmask == 3'h7) [*2] |-> irq.irq_b)
		else $error("interrupt raised with all sources masked");
	chk_port_mask_gate: assert property (
		(irq.pstat[0] && !irq.pmask[0]) |=> !irq.irq_b)
		else $error("unmasked port status did not raise interrupt");
	chk_irq_line_value: assert property (
		##1 irq.irq_b == !($past(|(irq.gstat & ~irq.gmask)) || $past(|(irq.pstat & ~irq.pmask))))
		else $error("interrupt line disagrees with masked status");

	cov_irq_raised: cover property ($fell(irq.irq_b));
endmodule

// File: core/sgc_sio_opt.sv
// Serial I/O options: preamble suppression and data-out launch edge
`timescale 1ns/1ns
module sgc_sio_opt
	import sgc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_sio_ctl,
	input wire logic i_sclk_fast,
	output logic o_preamble_opt,
	output logic o_sdo_rising
);
`include "sgc_consts.svh"

	sgc_sio_state_t st_ff;
	sgc_sio_state_t nxt_st;

	// Preamble option goes only to the MIIM slave; SPI and I2C never see it
	always_comb begin
		nxt_st = st_ff;
		nxt_st.preamble_opt = i_sio_ctl[`SGC_SIO_PRE_BIT];
		if (i_sio_ctl[`SGC_SIO_AUTO_BIT]) begin
			nxt_st.sdo_rising = i_sclk_fast;
		end else begin
			nxt_st.sdo_rising = i_sio_ctl[`SGC_SIO_EDGE_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= '{preamble_opt: 1'b0, sdo_rising: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_preamble_opt = st_ff.preamble_opt;
	assign o_sdo_rising = st_ff.sdo_rising;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// The outputs are still reset at the release edge, so that edge starts no check
	chk_preamble_opt_value: assert property (
		i_rst_b |=> o_preamble_opt == $past(i_sio_ctl[`SGC_SIO_PRE_BIT]))
		else $error("preamble option does not follow control bit");
	chk_sdo_auto_edge: assert property (
		(i_rst_b && i_sio_ctl[`SGC_SIO_AUTO_BIT]) |=>
		o_sdo_rising == $past(i_sclk_fast))
		else $error("automatic edge select wrong");
	chk_sdo_manual_edge: assert property (
		(i_rst_b && !i_sio_ctl[`SGC_SIO_AUTO_BIT]) |=>
		o_sdo_rising == $past(i_sio_ctl[`SGC_SIO_EDGE_BIT]))
		else $error("manual edge select wrong");

	cov_manual_rising: cover property (!i_sio_ctl[`SGC_SIO_AUTO_BIT] ##1 o_sdo_rising);
endmodule

// File: core/sgc_regs.sv
// Global control and interrupt register bank of a three-port switch
`timescale 1ns/1ns
module sgc_regs
	import sgc_pkg::*;
#(
	parameter int NUM_PORTS = 3,
	parameter logic [7:0] VARIANT_CODE = 8'hA5 // Arbitrary value
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic i_acc_miim,
	input wire logic [15:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_power_event,
	input wire logic i_lookup_irq,
	input wire logic i_gpio_irq,
	input wire logic [2:0] i_port_irq,
	input wire logic i_sclk_fast,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_power_event_pin_o,
	output logic o_power_event_pin_oe,
	output logic o_irq_b,
	output logic o_preamble_opt,
	output logic o_sdo_rising
);
`include "sgc_consts.svh"

	sgc_top_state_t st_ff;
	sgc_top_state_t nxt_st;
	sgc_irq_if irq_bus ();
	logic wr_ok;
	logic rd_ok;
	logic [31:0] gstat_word;
	logic [31:0] gmask_word;
	logic [31:0] pstat_word;
	logic [31:0] pmask_word;
	logic [7:0] rd_byte;

	// Pick one byte of a 32-bit register, lowest address holding the MSB
	function automatic logic [7:0] sel_byte(input logic [31:0] word, input logic [1:0] lane);
		logic [7:0] res;
		res = 8'h00;
		case (lane)
			2'h0: res = word[31:24];
			2'h1: res = word[23:16];
			2'h2: res = word[15:8];
			2'h3: res = word[7:0];
			default: res = 8'h00;
		endcase
		return res;
	endfunction

	// Interrupt aggregation
	sgc_irq_agg #(
		.NUM_PORTS(NUM_PORTS)
	) u_irq_agg (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_lookup_irq(i_lookup_irq),
		.i_gpio_irq(i_gpio_irq),
		.i_port_irq(i_port_irq),
		.irq(irq_bus.agg)
	);

	// Serial I/O options
	sgc_sio_opt u_sio_opt (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_sio_ctl(st_ff.sio_ctl),
		.i_sclk_fast(i_sclk_fast),
		.o_preamble_opt(o_preamble_opt),
		.o_sdo_rising(o_sdo_rising)
	);

	assign irq_bus.gmask = st_ff.gmask;
	assign irq_bus.pmask = st_ff.pmask;

	// MIIM accesses reach PHY registers only, so they are dropped here
	assign wr_ok = i_reg_wr && !i_acc_miim;
	assign rd_ok = i_reg_rd && !i_acc_miim;

	// Reserved bits of the 32-bit registers read as zero
	assign gstat_word = {irq_bus.gstat, 30'h0};
	assign gmask_word = {st_ff.gmask, 30'h0};
	assign pstat_word = {29'h0, irq_bus.pstat};
	assign pmask_word = {29'h0, st_ff.pmask};

	// Read decode; one byte per access, unmapped addresses read zero
	always_comb begin
		rd_byte = 8'h00;
		if (i_reg_addr == `SGC_ADDR_PWR_CTL) begin
			rd_byte = st_ff.pwr_ctl;
		end else if (i_reg_addr == `SGC_ADDR_VARIANT) begin
			rd_byte = VARIANT_CODE;
		end else if (i_reg_addr == `SGC_ADDR_SIO_CTL) begin
			rd_byte = st_ff.sio_ctl;
		end else if ((i_reg_addr & 16'hFFFC) == `SGC_ADDR_GSTAT) begin
			// Masking the lane bits lets all four byte addresses of the register match its base
			rd_byte = sel_byte(gstat_word, i_reg_addr[1:0]);
		end else if ((i_reg_addr & 16'hFFFC) == `SGC_ADDR_GMASK) begin
			rd_byte = sel_byte(gmask_word, i_reg_addr[1:0]);
		end else if ((i_reg_addr & 16'hFFFC) == `SGC_ADDR_PSTAT) begin
			rd_byte = sel_byte(pstat_word, i_reg_addr[1:0]);
		end else if ((i_reg_addr & 16'hFFFC) == `SGC_ADDR_PMASK) begin
			rd_byte = sel_byte(pmask_word, i_reg_addr[1:0]);
		end
	end

	// Next state: byte writes, read capture and the power-event pin
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		if (wr_ok) begin
			// Only the byte holding writable bits takes a write; others are ignored
			case (i_reg_addr)
				`SGC_ADDR_PWR_CTL: begin
					nxt_st.pwr_ctl = {6'h00, i_reg_wdata[1:0]};
				end
				`SGC_ADDR_GMASK: begin
					nxt_st.gmask = i_reg_wdata[7:6];
				end
				`SGC_ADDR_PMASK + 16'h0003: begin
					nxt_st.pmask = i_reg_wdata[2:0];
				end
				`SGC_ADDR_SIO_CTL: begin
					// Upper reserved field is writable and kept
					nxt_st.sio_ctl = i_reg_wdata;
				end
				default: begin
				end
			endcase
		end
		if (rd_ok) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_byte;
		end
		// Pin level is inverted for active-low; enable only drives the pad
		nxt_st.pwr_pin_oe = st_ff.pwr_ctl[`SGC_PWR_EN_BIT];
		if (st_ff.pwr_ctl[`SGC_PWR_POL_BIT]) begin
			nxt_st.pwr_pin_o = i_power_event;
		end else begin
			nxt_st.pwr_pin_o = ~i_power_event;
		end
	end

	// State register
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= '{pwr_ctl: `SGC_PWR_CTL_RST, sio_ctl: `SGC_SIO_CTL_RST,
				gmask: `SGC_GMASK_RST, pmask: `SGC_PMASK_RST, rdata: `SGC_RDATA_RST,
				rvalid: 1'b0, pwr_pin_o: 1'b1, pwr_pin_oe: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_reg_rdata = st_ff.rdata;
	assign o_reg_rvalid = st_ff.rvalid;
	assign o_power_event_pin_o = st_ff.pwr_pin_o;
	assign o_power_event_pin_oe = st_ff.pwr_pin_oe;
	assign o_irq_b = irq_bus.irq_b;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// Properties that look one cycle back skip the release edge, where state is still reset
	chk_pin_enable_write: assert property (
		(wr_ok && i_reg_addr == `SGC_ADDR_PWR_CTL) |-> ##2
		o_power_event_pin_oe == $past(i_reg_wdata[1], 2))
		else $error("pin enable does not follow written bit");
	chk_pin_oe_disabled: assert property (
		(i_rst_b && !st_ff.pwr_ctl[`SGC_PWR_EN_BIT]) |=> !o_power_event_pin_oe)
		else $error("pin driven while output disabled");
	chk_pin_level_polarity: assert property (
		i_rst_b |=> o_power_event_pin_o == ($past(st_ff.pwr_ctl[0]) ~^ $past(i_power_event)))
		else $error("power-event pin level wrong for polarity");
	chk_variant_read: assert property (
		(rd_ok && i_reg_addr == `SGC_ADDR_VARIANT) |=>
		(o_reg_rvalid && o_reg_rdata == VARIANT_CODE))
		else $error("variant code read wrong");
	chk_glb_status_read: assert property (
		(rd_ok && i_reg_addr == `SGC_ADDR_GSTAT) |=>
		o_reg_rdata == {$past(irq_bus.gstat), 6'h00})
		else $error("global status byte read wrong");
	chk_port_status_read: assert property (
		(rd_ok && i_reg_addr == `SGC_ADDR_PSTAT + 16'h0003) |=>
		o_reg_rdata == {5'h00, $past(irq_bus.pstat)})
		else $error("port summary status byte read wrong");
	chk_pmask_write: assert property (
		(wr_ok && i_reg_addr == `SGC_ADDR_PMASK + 16'h0003) |=>
		st_ff.pmask == $past(i_reg_wdata[2:0]))
		else $error("port mask write lost");
	chk_sio_write: assert property (
		(wr_ok && i_reg_addr == `SGC_ADDR_SIO_CTL) |=>
		st_ff.sio_ctl == $past(i_reg_wdata))
		else $error("serial I/O control write lost");
	chk_miim_blocked: assert property (
		i_acc_miim |=> !o_reg_rvalid)
		else $error("MIIM access answered");
	chk_miim_write_ignored: assert property (
		(i_rst_b && i_acc_miim) |=> ($stable(st_ff.pwr_ctl) && $stable(st_ff.sio_ctl)
		&& $stable(st_ff.gmask) && $stable(st_ff.pmask)))
		else $error("MIIM write changed a register");
	chk_rvalid_pulse: assert property (
		i_rst_b |=> o_reg_rvalid == $past(rd_ok))
		else $error("read answer not one pulse per accepted read");
	chk_gmask_big_endian: assert property (
		(rd_ok && i_reg_addr == `SGC_ADDR_GMASK) |=>
		o_reg_rdata == {$past(st_ff.gmask), 6'h00})
		else $error("global mask top byte misplaced");
	chk_gmask_low_bytes: assert property (
		(wr_ok && (i_reg_addr & 16'hFFFC) == `SGC_ADDR_GMASK && i_reg_addr[1:0] != 2'h0)
		|=> $stable(st_ff.gmask))
		else $error("global mask changed by a reserved byte write");
	chk_reserved_byte_read: assert property (
		(rd_ok && i_reg_addr == `SGC_ADDR_GSTAT + 16'h0003) |=> o_reg_rdata == 8'h00)
		else $error("reserved status byte not zero");
	chk_reserved_zero: assert property (
		st_ff.pwr_ctl[7:2] == 6'h00)
		else $error("reserved power-event bits changed");

	cov_variant_read: cover property (rd_ok && i_reg_addr == `SGC_ADDR_VARIANT);
	cov_pin_driven_high: cover property (o_power_event_pin_oe && o_power_event_pin_o);
endmodule

// File: bench/sgc_host_model.sv
// Management host model issuing byte reads and writes to the register bank
`timescale 1ns/1ns
module sgc_host_model (
	input wire logic i_core_clk,
	input wire logic [7:0] i_reg_rdata,
	input wire logic i_reg_rvalid,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic o_acc_miim,
	output logic [15:0] o_reg_addr,
	output logic [7:0] o_reg_wdata
);
	// Idle bus at time zero
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_acc_miim = 1'b0;
		o_reg_addr = 16'h0000;
		o_reg_wdata = 8'h00;
	end

	// One byte access; released address and data lines show inverted values so stale data never matches
	task automatic access(input logic rd, input logic miim, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge i_core_clk);
		o_reg_rd <= rd;
		o_reg_wr <= ~rd;
		o_acc_miim <= miim;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(posedge i_core_clk);
		o_reg_rd <= 1'b0;
		o_reg_wr <= 1'b0;
		o_acc_miim <= 1'b0;
		o_reg_addr <= ~a;
		o_reg_wdata <= ~d;
	endtask

	// Bounded wait for the read answer, sampled mid-cycle
	task automatic get(output logic [7:0] q, output logic ok);
		ok = 1'b0;
		q = 8'h00;
		for (int k = 0; k < 4 && !ok; k++) begin
			@(negedge i_core_clk);
			if (i_reg_rvalid === 1'b1) begin
				ok = 1'b1;
				q = i_reg_rdata;
			end
		end
	endtask
endmodule

// File: bench/sgc_regs_tb.sv
// Self-checking bench of the global control and interrupt register bank
`timescale 1ns/1ns
module sgc_regs_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic pe = 1'b0;
	logic lk = 1'b0;
	logic gp = 1'b0;
	logic [2:0] pi = 3'h0;
	logic fast = 1'b1;
	logic wr, rd, miim, rv, pin, oe, irq_b, pre, serial_data_output, ok;
	logic [15:0] addr;
	logic [7:0] wd, rdat, q, b;
	logic [1:0] gm;
	logic [2:0] pm;
	int err_count = 0;
	int samples_checked = 0;
	logic [15:0] ra [6] = '{16'h0006, 16'h0100, 16'h0014, 16'h001F, 16'h000F, 16'h0200};
	logic [7:0] rx [6] = '{8'h00, 8'h42, 8'h00, 8'h00, 8'h5E, 8'h00};

	always #50 clk = ~clk;

	// Variant code is arbitrary
	sgc_regs #(.NUM_PORTS(3), .VARIANT_CODE(8'h5E)) uut (.i_core_clk(clk), .i_rst_b(rst_b),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_acc_miim(miim), .i_reg_addr(addr),
		.i_reg_wdata(wd), .i_power_event(pe), .i_lookup_irq(lk), .i_gpio_irq(gp),
		.i_port_irq(pi), .i_sclk_fast(fast), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
		.o_power_event_pin_o(pin), .o_power_event_pin_oe(oe), .o_irq_b(irq_b),
		.o_preamble_opt(pre), .o_sdo_rising(serial_data_output));

	sgc_host_model host (.i_core_clk(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
		.o_reg_wr(wr), .o_reg_rd(rd), .o_acc_miim(miim), .o_reg_addr(addr),
		.o_reg_wdata(wd));

	// Verdict and the only exit
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cmp_bit(input string n, input logic e, input logic s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %b seen %b", n, e, s);
		end
	endtask

	// Read one byte and compare; a missing answer ends the run
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		host.access(1'b1, 1'b0, a, 8'h00);
		host.get(q, ok);
		if (!ok) begin
			err_count++;
			end_sim();
		end
		cmp_byte($sformatf("addr %h", a), e, q);
		// The answer stands for one cycle only
		@(negedge clk);
		cmp_bit("rvalid_pulse", 1'b0, rv);
	endtask

	// Let outputs with two-cycle lag settle, then sample mid-cycle
	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic exp_irq_b();
		return ~(|({lk, gp} & ~gm) | |(pi & ~pm));
	endfunction

	initial begin
		q = 8'($urandom(32'h7B8C27BD));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		cmp_bit("pin_oe", 1'b0, oe);
		cmp_bit("irq_b", 1'b1, irq_b);
		cmp_bit("preamble", 1'b0, pre);
		for (int i = 0; i < 6; i++) begin
			rchk(ra[i], rx[i]);
		end
		cmp_bit("sdo_rising", fast, serial_data_output);
		// Writes to read-only places and from the MIIM side must vanish
		host.access(1'b0, 1'b0, 16'h000F, 8'hFF);
		host.access(1'b0, 1'b0, 16'h0010, 8'hFF);
		host.access(1'b0, 1'b0, 16'h0015, 8'hFF);
		host.access(1'b0, 1'b1, 16'h0006, 8'h03);
		rchk(16'h000F, 8'h5E);
		rchk(16'h0006, 8'h00);
		rchk(16'h0014, 8'h00);
		// A read from the MIIM side gets no answer at all
		host.access(1'b1, 1'b1, 16'h000F, 8'h00);
		host.get(q, ok);
		cmp_bit("miim_read_answer", 1'b0, ok);
		for (int i = 0; i < 8; i++) begin
			b = 8'($urandom);
			b[1:0] = i[1:0];
			host.access(1'b0, 1'b0, 16'h0006, b);
			@(posedge clk);
			pe <= i[2];
			settle();
			cmp_bit("pin_oe", b[1], oe);
			if (b[1]) begin
				cmp_bit("pin_o", ~(b[0] ^ pe), pin);
			end
			rchk(16'h0006, {6'h00, b[1:0]});
		end
		// Random sources and masks; first pass has everything pending and masked
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			{lk, gp, pi} <= (i == 0) ? 5'h1F : 5'($urandom);
			gm = (i == 0) ? 2'h3 : 2'($urandom);
			pm = (i == 0) ? 3'h7 : 3'($urandom);
			b = 8'($urandom);
			host.access(1'b0, 1'b0, 16'h0014, {gm, b[5:0]});
			host.access(1'b0, 1'b0, 16'h001F, {b[7:3], pm});
			settle();
			cmp_bit("irq_b", exp_irq_b(), irq_b);
			rchk(16'h0010, {lk, gp, 6'h00});
			rchk(16'h0013, 8'h00);
			rchk(16'h0014, {gm, 6'h00});
			rchk(16'h001B, {5'h00, pi});
			rchk(16'h001F, {5'h00, pm});
		end
		// Every combination of preamble, auto and manual edge bits
		for (int i = 0; i < 8; i++) begin
			b = 8'($urandom);
			b[2:0] = i[2:0];
			@(posedge clk);
			fast <= 1'($urandom);
			host.access(1'b0, 1'b0, 16'h0100, b);
			settle();
			cmp_bit("preamble", b[2], pre);
			cmp_bit("sdo_rising", b[1] ? fast : b[0], serial_data_output);
			rchk(16'h0100, b);
		end
		// Mid-run reset with sources still pending must restore the register, pin-enable and serial I/O reset values
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		cmp_bit("pin_oe", 1'b0, oe);
		cmp_bit("preamble", 1'b0, pre);
		cmp_bit("sdo_rising", 1'b0, serial_data_output);
		for (int i = 0; i < 6; i++) begin
			rchk(ra[i], rx[i]);
		end
		cmp_bit("sdo_rising", fast, serial_data_output);
		gm = 2'h0;
		pm = 3'h0;
		cmp_bit("irq_b", exp_irq_b(), irq_b);
		end_sim();
	end
endmodule
